// >>> logic/gos_cfg.svh
`ifndef GOS_CFG_SVH
`define GOS_CFG_SVH

// ==========================================================================
// Bus geometry
`define GOS_ADDR_W       8
`define GOS_DATA_W       32

// ==========================================================================
// Register byte offsets
`define GOS_OFF_DIR01    8'h10
`define GOS_OFF_OUT01    8'h14
`define GOS_OFF_SET01    8'h18
`define GOS_OFF_CLR01    8'h1c
`define GOS_OFF_IN01     8'h20
`define GOS_OFF_DIR2     8'h38
`define GOS_OFF_OUT2     8'h3c
`define GOS_OFF_SET2     8'h40
`define GOS_OFF_CLR2     8'h44
`define GOS_OFF_IN2      8'h48

// ==========================================================================
// Implemented pin bits and reset values
`define GOS_MASK01       32'h03ff3dff
`define GOS_MASK2        32'h0000ffff
`define GOS_BANK0_LSB    0
`define GOS_BANK1_LSB    16
`define GOS_BANK2_W      16
`define GOS_DIR_RST      32'hffffffff
`define GOS_OUT_RST      32'h00000000
`define GOS_RD_IDLE      32'h00000000

`endif

// >>> logic/gos_pkg.sv
`include "gos_cfg.svh"

package gos_pkg;

    // ======================================================================
    // Register bus request as one bundle
    typedef struct packed {
        logic [`GOS_ADDR_W-1:0] addr;
        logic [`GOS_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } gos_req_s;

    // ======================================================================
    // Register selects, at most one set, plus a hit flag raised with any of them
    typedef struct packed {
        logic dir01;
        logic out01;
        logic set01;
        logic clr01;
        logic in01;
        logic dir2;
        logic out2;
        logic set2;
        logic clr2;
        logic in2;
        logic hit;
    } gos_sel_s;

endpackage : gos_pkg

// >>> logic/gos_sync.sv
`timescale 1ns/1ns

module gos_sync #(
    parameter int W = 48
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    // ======================================================================
    // Two-stage pin synchroniser; first stage feeds only the second
    logic [W-1:0] stage1;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule // gos_sync

// >>> logic/gos_regdec.sv
`timescale 1ns/1ns
`include "gos_cfg.svh"

module gos_regdec import gos_pkg::*; (
    input  wire gos_req_s req,
    output gos_sel_s      sel
);

    // ======================================================================
    // Address decode
    always_comb begin
        sel       = '0;
        sel.dir01 = (req.addr == `GOS_OFF_DIR01);
        sel.out01 = (req.addr == `GOS_OFF_OUT01);
        sel.set01 = (req.addr == `GOS_OFF_SET01);
        sel.clr01 = (req.addr == `GOS_OFF_CLR01);
        sel.in01  = (req.addr == `GOS_OFF_IN01);
        sel.dir2  = (req.addr == `GOS_OFF_DIR2);
        sel.out2  = (req.addr == `GOS_OFF_OUT2);
        sel.set2  = (req.addr == `GOS_OFF_SET2);
        sel.clr2  = (req.addr == `GOS_OFF_CLR2);
        sel.in2   = (req.addr == `GOS_OFF_IN2);
        sel.hit   = sel.dir01 | sel.out01 | sel.set01 | sel.clr01 | sel.in01 |
                    sel.dir2 | sel.out2 | sel.set2 | sel.clr2 | sel.in2;
    end

endmodule // gos_regdec

// >>> logic/gos_top.sv
// What this block does
// RULE1 - Writing 1 to a set bit drives that pin's state high; 0 does nothing.
// RULE2 - Writing 1 to a clear bit drives that pin's state low; 0 does nothing.
// RULE3 - Set and clear writes touch only pins whose direction bit is 0.
// RULE4 - Reading set or clear register returns present output drive state.
// RULE5 - Shared word: high half is bank 1, low half bank 0; bank 2 own word.
// RULE6 - Banks 0/1 clear word: bits 9, 14-15, 26-31 reserved, read 0.
// RULE7 - Direction bit 0 drives pin from state; 1 makes pin an input.
// RULE8 - Set/clear change the same state the output data register stores and returns.
// RULE9 - Selected bits update together on the write's clock edge, seen by next read.
`timescale 1ns/1ns
`include "gos_cfg.svh"

module gos_top import gos_pkg::*; (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic [`GOS_ADDR_W-1:0] addr,
    input  wire logic [`GOS_DATA_W-1:0] wdata,
    input  wire logic                   wr_stb,
    input  wire logic                   rd_stb,
    output logic      [`GOS_DATA_W-1:0] rd_data,
    output logic      [31:0]            pin_out01,
    output logic      [31:0]            pin_oe01,
    input  wire logic [31:0]            pin_in01,
    output logic      [`GOS_BANK2_W-1:0] pin_out2,
    output logic      [`GOS_BANK2_W-1:0] pin_oe2,
    input  wire logic [`GOS_BANK2_W-1:0] pin_in2
);

    // ======================================================================
    // Bus request and decode
    gos_req_s req;
    gos_sel_s sel;

    assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

    gos_regdec u_dec (
        .req (req),
        .sel (sel)
    );

    // ======================================================================
    // Pin input synchroniser, read back through the input words
    logic [31:0]              in01_sync;
    logic [`GOS_BANK2_W-1:0]  in2_sync;

    gos_sync #(
        .W (32 + `GOS_BANK2_W)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .din     ({pin_in2, pin_in01}),
        .dout    ({in2_sync, in01_sync})
    );

    // ======================================================================
    // Drive state update
    // One shared function keeps the bank 0/1 word's and bank 2's write semantics identical.
    function automatic logic [31:0] drive_next(
        input logic [31:0] cur,
        input logic [31:0] dir,
        input logic [31:0] mask,
        input logic [31:0] setm,
        input logic [31:0] clrm,
        input logic [31:0] wval,
        input logic        wen
    );
        logic [31:0] en;
        logic [31:0] r;
        en = mask & ~dir;                                      // RULE3 RULE6
        r  = cur;
        if (wen) begin
            r = (cur & ~en) | (wval & en);                     // RULE8
        end
        r = r | (setm & en);                                   // RULE1
        r = r & ~(clrm & en);                                  // RULE2
        return r;
    endfunction

    logic [31:0] dir01;
    logic [31:0] dir2;
    logic [31:0] out01;
    logic [31:0] out2;
    logic [31:0] next_out01;
    logic [31:0] next_out2;
    logic [31:0] set01_m;
    logic [31:0] clr01_m;
    logic [31:0] set2_m;
    logic [31:0] clr2_m;

    // Each word's set/clear masks only see their own register selects
    assign set01_m = (req.wr && sel.set01) ? req.wdata : '0;   // RULE5
    assign clr01_m = (req.wr && sel.clr01) ? req.wdata : '0;   // RULE5
    assign set2_m  = (req.wr && sel.set2)  ? req.wdata : '0;   // RULE5
    assign clr2_m  = (req.wr && sel.clr2)  ? req.wdata : '0;   // RULE5

    always_comb begin
        next_out01 = drive_next(out01, dir01, `GOS_MASK01, set01_m, clr01_m,
                                req.wdata, req.wr && sel.out01);
        next_out2  = drive_next(out2, dir2, `GOS_MASK2, set2_m, clr2_m,
                                req.wdata, req.wr && sel.out2);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out01 <= `GOS_OUT_RST;
            out2  <= `GOS_OUT_RST;
        end else begin
            out01 <= next_out01;                               // RULE9
            out2  <= next_out2;                                // RULE9
        end
    end

    // ======================================================================
    // Direction registers; reserved bits held at 1 so they never drive
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir01 <= `GOS_DIR_RST;
            dir2  <= `GOS_DIR_RST;
        end else begin
            if (req.wr && sel.dir01) begin
                dir01 <= req.wdata | ~`GOS_MASK01;
            end
            if (req.wr && sel.dir2) begin
                dir2 <= req.wdata | ~`GOS_MASK2;
            end
        end
    end

    // ======================================================================
    // Pin drive
    assign pin_oe01  = ~dir01;                                 // RULE7
    assign pin_out01 = out01;                                  // RULE7
    assign pin_oe2   = ~dir2[`GOS_BANK2_W-1:0];                // RULE7
    assign pin_out2  = out2[`GOS_BANK2_W-1:0];                 // RULE7

    // ======================================================================
    // Read path; data stand for one cycle only, unmapped reads give zero
    logic [31:0] next_rd;

    always_comb begin
        next_rd = `GOS_RD_IDLE;
        if (sel.dir01) begin
            next_rd = dir01;
        end else if (sel.out01 || sel.set01 || sel.clr01) begin
            next_rd = out01 & `GOS_MASK01;                     // RULE4 RULE6 RULE8
        end else if (sel.in01) begin
            next_rd = in01_sync & `GOS_MASK01;
        end else if (sel.dir2) begin
            next_rd = dir2;
        end else if (sel.out2 || sel.set2 || sel.clr2) begin
            next_rd = out2 & `GOS_MASK2;                       // RULE4
        end else if (sel.in2) begin
            next_rd = {16'h0000, in2_sync} & `GOS_MASK2;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= `GOS_RD_IDLE;
        end else begin
            rd_data <= (req.rd && sel.hit) ? next_rd : `GOS_RD_IDLE;
        end
    end

    // ======================================================================
    // Checks
    logic [31:0] eff01;
    logic [31:0] eff2;
    logic [31:0] held01;
    logic [31:0] wr_out01;
    logic [31:0] held2;
    logic [31:0] wr_out2;

    assign eff01    = req.wdata & `GOS_MASK01 & ~dir01;
    assign eff2     = req.wdata & `GOS_MASK2 & ~dir2;
    assign held01   = out01 & dir01;
    assign wr_out01 = (out01 & ~(`GOS_MASK01 & ~dir01)) | eff01;
    assign held2    = out2 & dir2;
    assign wr_out2  = (out2 & ~(`GOS_MASK2 & ~dir2)) | eff2;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_SET_HIGH: assert property ( // RULE1
        wr_stb && sel.set01 |=> ((out01 & $past(eff01)) == $past(eff01)))
        else $error("set write did not drive selected bits high");

    AST_SET_KEEP: assert property ( // RULE1
        wr_stb && sel.set01 |=> ((out01 & ~$past(eff01)) == ($past(out01) & ~$past(eff01))))
        else $error("set write changed unselected bits");

    AST_CLR_LOW: assert property ( // RULE2
        wr_stb && sel.clr01 |=> ((out01 & $past(eff01)) == 32'h00000000))
        else $error("clear write did not drive selected bits low");

    AST_CLR2_KEEP: assert property ( // RULE2
        wr_stb && sel.clr2 |=> ((out2 & ~$past(eff2)) == ($past(out2) & ~$past(eff2))))
        else $error("bank 2 clear write changed unselected bits");

    AST_INPUT_UNTOUCHED: assert property ( // RULE3
        wr_stb && (sel.set01 || sel.clr01) |=> ((out01 & $past(dir01)) == $past(held01)))
        else $error("set or clear changed an input pin state");

    AST_READ_STATE: assert property ( // RULE4
        rd_stb && (sel.set01 || sel.clr01) |=> (rd_data == $past(out01)))
        else $error("set or clear read did not return drive state");

    AST_BANK2_ISOLATED: assert property ( // RULE5
        wr_stb && (sel.set2 || sel.clr2) |=> (out01 == $past(out01)))
        else $error("bank 2 write disturbed banks 0 and 1");

    AST_RSV_ZERO: assert property ( // RULE6
        rd_stb && sel.clr01 |=> ((rd_data & ~`GOS_MASK01) == 32'h00000000))
        else $error("reserved clear bits read nonzero");

    AST_PIN_DIR: assert property ( // RULE7
        (pin_oe01 == (~dir01 & `GOS_MASK01)) && ((pin_out01 & pin_oe01) == (out01 & pin_oe01)))
        else $error("pin drive does not follow direction and state");

    AST_OUT_SHARED: assert property ( // RULE8
        wr_stb && sel.out01 |=> (out01 == $past(wr_out01)))
        else $error("output data write did not land in drive state");

    AST_NEXT_READ: assert property ( // RULE9
        (wr_stb && sel.set01 ##1 rd_stb && sel.out01)
            |=> ((rd_data & $past(eff01, 2)) == $past(eff01, 2)))
        else $error("set write not visible to next read");

    AST_SET2_HIGH: assert property ( // RULE1
        wr_stb && sel.set2 |=> ((out2 & $past(eff2)) == $past(eff2)))
        else $error("bank 2 set write did not drive selected bits high");

    AST_SET2_KEEP: assert property ( // RULE1
        wr_stb && sel.set2 |=> ((out2 & ~$past(eff2)) == ($past(out2) & ~$past(eff2))))
        else $error("bank 2 set write changed unselected bits");

    AST_CLR_KEEP: assert property ( // RULE2
        wr_stb && sel.clr01 |=> ((out01 & ~$past(eff01)) == ($past(out01) & ~$past(eff01))))
        else $error("clear write changed unselected bits");

    AST_CLR2_LOW: assert property ( // RULE2
        wr_stb && sel.clr2 |=> ((out2 & $past(eff2)) == 32'h00000000))
        else $error("bank 2 clear write did not drive selected bits low");

    AST_INPUT2_UNTOUCHED: assert property ( // RULE3
        wr_stb && (sel.set2 || sel.clr2) |=> ((out2 & $past(dir2)) == $past(held2)))
        else $error("bank 2 set or clear changed an input pin state");

    AST_READ2_STATE: assert property ( // RULE4
        rd_stb && (sel.set2 || sel.clr2) |=> (rd_data == $past(out2)))
        else $error("bank 2 set or clear read did not return drive state");

    AST_RD_ONE_CYCLE: assert property ( // RULE4
        !rd_stb |=> (rd_data == `GOS_RD_IDLE))
        else $error("read data stood without a read strobe");

    AST_BANK01_ISOLATED: assert property ( // RULE5
        wr_stb && (sel.set01 || sel.clr01 || sel.out01) |=> (out2 == $past(out2)))
        else $error("banks 0 and 1 write disturbed bank 2");

    AST_BANK2_UPPER: assert property ( // RULE5
        (out2 & ~`GOS_MASK2) == 32'h00000000)
        else $error("bank 2 state holds bits above its pins");

    AST_RSV_STATE: assert property ( // RULE6
        (out01 & ~`GOS_MASK01) == 32'h00000000)
        else $error("reserved drive state bits set");

    AST_RSV_NO_DRIVE: assert property ( // RULE6
        (pin_oe01 & ~`GOS_MASK01) == 32'h00000000)
        else $error("reserved pin enabled as output");

    AST_PIN2_DIR: assert property ( // RULE7
        (pin_oe2 == ~dir2[`GOS_BANK2_W-1:0]) &&
        ((pin_out2 & pin_oe2) == (out2[`GOS_BANK2_W-1:0] & pin_oe2)))
        else $error("bank 2 pin drive does not follow direction and state");

    AST_OUT2_SHARED: assert property ( // RULE8
        wr_stb && sel.out2 |=> (out2 == $past(wr_out2)))
        else $error("bank 2 output data write did not land in drive state");

    AST_OUT_READ: assert property ( // RULE8
        rd_stb && sel.out01 |=> (rd_data == $past(out01)))
        else $error("output data read did not return stored state");

    AST_OUT2_READ: assert property ( // RULE8
        rd_stb && sel.out2 |=> (rd_data == $past(out2)))
        else $error("bank 2 output data read did not return stored state");

    AST_NEXT_CLEAR_READ: assert property ( // RULE9
        (wr_stb && sel.clr01 ##1 rd_stb && sel.set01)
            |=> ((rd_data & $past(eff01, 2)) == 32'h00000000))
        else $error("clear write not visible to next read");

    AST_IDLE_HOLD: assert property ( // RULE9
        !wr_stb |=> ((out01 == $past(out01)) && (out2 == $past(out2))))
        else $error("drive state changed without a write");

    COV_SET_OUTPUT: cover property (wr_stb && sel.set01 && (eff01 != 32'h00000000));
    COV_CLR_OUTPUT: cover property (wr_stb && sel.clr01 && (eff01 != 32'h00000000));
    COV_SET_INPUT:  cover property (wr_stb && sel.set01 && ((req.wdata & dir01) != 32'h0));
    COV_BANK2:      cover property (wr_stb && (sel.set2 || sel.clr2) ##1
                                    rd_stb && (sel.set2 || sel.clr2));
    COV_READ_STATE: cover property (rd_stb && (sel.set01 || sel.clr01));

endmodule // gos_top

// >>> bench/gos_pin_model.sv
`timescale 1ns/1ns

module gos_pin_model (
    input  wire logic        sys_clk,
    input  wire logic [31:0] pin_out01,
    input  wire logic [31:0] pin_oe01,
    input  wire logic [15:0] pin_out2,
    input  wire logic [15:0] pin_oe2,
    output logic      [31:0] pin_in01,
    output logic      [15:0] pin_in2
);
    // ======================================================================
    // Far-side level on undriven pins
    // Toggles each cycle so a stale value can never pass for a real one
    logic [31:0] ext_level = 32'h5a5a5a5a;

    always @(posedge sys_clk) begin
        ext_level <= ~ext_level;
    end

    // ======================================================================
    // Wire level: the enabled driver wins, otherwise the outside world
    always_comb begin
        pin_in01 = (pin_oe01 & pin_out01) | (~pin_oe01 & ext_level);
        pin_in2  = (pin_oe2 & pin_out2) | (~pin_oe2 & ext_level[15:0]);
    end
endmodule // gos_pin_model

// >>> bench/tb_gpio_output_set_clear.sv
`timescale 1ns/1ns
`include "gos_cfg.svh"

module tb_gpio_output_set_clear;
    logic        sys_clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rd_data;
    logic [31:0] pin_out01;
    logic [31:0] pin_oe01;
    logic [31:0] pin_in01;
    logic [15:0] pin_out2;
    logic [15:0] pin_oe2;
    logic [15:0] pin_in2;
    logic [31:0] rd_seen;
    logic [31:0] out_seen;
    logic [31:0] oe_seen;
    logic [15:0] out2_seen;
    logic [15:0] oe2_seen;
    int          errors;
    int          checked;
    localparam logic [31:0] M = `GOS_MASK01;

    gos_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .pin_out01(pin_out01),
        .pin_oe01(pin_oe01), .pin_in01(pin_in01), .pin_out2(pin_out2),
        .pin_oe2(pin_oe2), .pin_in2(pin_in2));

    gos_pin_model pins_u (.sys_clk(sys_clk), .pin_out01(pin_out01), .pin_oe01(pin_oe01),
        .pin_out2(pin_out2), .pin_oe2(pin_oe2), .pin_in01(pin_in01), .pin_in2(pin_in2));

    // ======================================================================
    // Clock and mid-cycle sampling of outputs, clear of any edge race
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) begin
        rd_seen  <= rd_data;
        out_seen <= pin_out01;
        oe_seen  <= pin_oe01;
        out2_seen <= pin_out2;
        oe2_seen <= pin_oe2;
    end

    // ======================================================================
    // Bus helpers: every call starts and ends at a rising edge
    task automatic cyc(input logic w, input logic r, input logic [7:0] a,
                       input logic [31:0] d);
        wr_stb <= w;
        rd_stb <= r;
        addr   <= a;
        wdata  <= d;
        @(posedge sys_clk);
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cyc(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        cyc(1'b0, 1'b1, a, 32'h0);
        cyc(1'b0, 1'b0, 8'h00, 32'h0);
        chk(what, exp, rd_seen);
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_reset();
        rd("set01 after reset", `GOS_OFF_SET01, 32'h0);
        chk("oe01 after reset", 32'h0, oe_seen);
        chk("pin_out01 after reset", 32'h0, out_seen);
    endtask

    task automatic t_set_clear01();
        wr(`GOS_OFF_DIR01, 32'h0);
        wr(`GOS_OFF_SET01, 32'hffffffff);
        rd("set01 readback", `GOS_OFF_SET01, M);
        rd("clr01 readback", `GOS_OFF_CLR01, M);
        rd("out01 readback", `GOS_OFF_OUT01, M);
        chk("pin_out01", M, out_seen);
        chk("pin_oe01", M, oe_seen);
        rd("in01 readback", `GOS_OFF_IN01, M);
        wr(`GOS_OFF_CLR01, 32'h0000ffff);
        rd("clr01 low half", `GOS_OFF_CLR01, M & 32'hffff0000);
        chk("pin_out01 bank1", M & 32'hffff0000, out_seen);
    endtask

    task automatic t_dir_gate();
        wr(`GOS_OFF_SET01, 32'hffffffff);
        wr(`GOS_OFF_DIR01, 32'h0000ffff);
        wr(`GOS_OFF_CLR01, 32'hffffffff);
        rd("clr01 inputs kept", `GOS_OFF_SET01, M & 32'h0000ffff);
        wr(`GOS_OFF_DIR01, 32'hffff0000);
        wr(`GOS_OFF_SET01, 32'hffffffff);
        rd("set01 inputs kept", `GOS_OFF_OUT01, M & 32'h0000ffff);
        rd("dir01 readback", `GOS_OFF_DIR01, 32'hffff0000 | ~M);
        wr(`GOS_OFF_OUT01, 32'h00000000);
        rd("out01 direct write", `GOS_OFF_CLR01, 32'h0);
        wr(`GOS_OFF_OUT01, 32'hffffffff);
        rd("out01 inputs kept", `GOS_OFF_SET01, M & 32'h0000ffff);
        wr(`GOS_OFF_DIR01, 32'h0);
        wr(`GOS_OFF_CLR01, 32'h0000ff00);
        rd("back to back", `GOS_OFF_OUT01, M & 32'h000000ff);
    endtask

    task automatic t_bank2();
        wr(`GOS_OFF_DIR2, 32'h0);
        wr(`GOS_OFF_SET2, 32'hffff00a5);
        rd("clr2 readback", `GOS_OFF_CLR2, 32'h000000a5);
        wr(`GOS_OFF_CLR2, 32'h00000005);
        rd("set2 readback", `GOS_OFF_SET2, 32'h000000a0);
        chk("pin_out2", 32'h000000a0, {16'h0, out2_seen});
        chk("pin_oe2", 32'h0000ffff, {16'h0, oe2_seen});
        wr(`GOS_OFF_DIR2, 32'h0000ff00);
        wr(`GOS_OFF_SET2, 32'hffffffff);
        rd("set2 inputs kept", `GOS_OFF_CLR2, 32'h000000ff);
        chk("pin_oe2 low byte", 32'h000000ff, {16'h0, oe2_seen});
        rd("bank2 kept out01", `GOS_OFF_OUT01, M & 32'h000000ff);
        rd("unmapped read", 8'hfc, 32'h0);
    endtask

    task automatic t_mid_reset();
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd("set2 after reset", `GOS_OFF_SET2, 32'h0);
        chk("oe2 after reset", 32'h0, {16'h0, oe2_seen});
        rd("out01 after reset", `GOS_OFF_OUT01, 32'h0);
    endtask

    // ======================================================================
    // Sequence, verdict and watchdog
    task automatic complete_run();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        errors  = 0;
        checked = 0;
        rst_n   = 1'b0;
        wr_stb  = 1'b0;
        rd_stb  = 1'b0;
        addr    = 8'h00;
        wdata   = 32'h0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_set_clear01();
        t_dir_gate();
        t_bank2();
        t_mid_reset();
        complete_run();
    end

    initial begin
        repeat (2000) @(posedge sys_clk);
        errors++;
        complete_run();
    end
endmodule // tb_gpio_output_set_clear
